// >>> hw/adcrb_bank.sv
// Read-only converter result register bank behind a classic Wishbone slave.
// Assumes the converter core posts results on clk_i through conv_i.
//
// What this block does
// - Bits five down to one of every low-byte register always read as ones.
// - Bit zero of each low-byte register shows whether a result is stored for that pair.
// - A converter write into a pair sets that pair's stored flag.
// - A bus read of either byte of a pair clears that pair's stored flag, unless a converter write to that pair sets it on the same edge.
// - Each high-byte register reads the upper eight result bits of its pair.
`default_nettype none

module adcrb_bank
	import adcrb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire adcrb_conv_s conv_i,
	output logic [NUM_PAIRS-1:0] stored_flags_o
);

	// ----------------------------------------------------------------
	// Pair storage
	// ----------------------------------------------------------------
	logic [9:0] result [NUM_PAIRS];
	logic [NUM_PAIRS-1:0] flag;
	logic [NUM_PAIRS-1:0] rd_clr;
	logic [NUM_PAIRS-1:0] conv_wr;

	// One pair module per channel pair
	for (genvar k = 0; k < NUM_PAIRS; k++) begin : g_pair
		assign conv_wr[k] = conv_i.wr && (conv_i.pair == 2'(k));
		adcrb_pair u_pair (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.wr_i(conv_wr[k]),
			.data_i(conv_i.data),
			.rd_clr_i(rd_clr[k]),
			.result_o(result[k]),
			.flag_o(flag[k])
		);
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [IDX_W-1:0] idx;
	logic [IDX_W-1:0] off;
	logic hit;
	logic [1:0] sel_pair;
	logic sel_high;
	logic take;
	logic [7:0] rd_byte;

	// Index, pair and byte selection for the current request
	always_comb begin
		idx = wb_adr_i[ADDR_W-1:2];
		off = idx - IDX_PAIR15_LOW;
		hit = (idx >= IDX_PAIR15_LOW) && (idx <= IDX_PAIR37_HIGH);
		sel_pair = off[2:1];
		sel_high = off[0];
		take = wb_cyc_i && wb_stb_i && !wb_ack_o;
		rd_byte = 8'h00;
		if (hit && sel_pair < 2'(NUM_PAIRS)) begin
			if (sel_high) begin
				rd_byte = result[sel_pair][9:2];
			end else begin
				rd_byte[7:RES_LO_LSB] = result[sel_pair][1:0];
				rd_byte[FILL_MSB:FILL_LSB] = LOW_FILL;
				rd_byte[FLAG_BIT] = flag[sel_pair];
			end
		end
	end

	// Read side effect: clear the addressed pair's flag once per access
	// Writes never clear; the answer still shows the flag from before the clear
	always_comb begin
		rd_clr = '0;
		for (int k = 0; k < NUM_PAIRS; k++) begin
			if (take && !wb_we_i && hit && sel_pair == 2'(k)) begin
				rd_clr[k] = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Answer registers
	// ----------------------------------------------------------------
	logic ack_reg;
	logic ack_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	logic [NUM_PAIRS-1:0] flags_reg;
	logic [NUM_PAIRS-1:0] flags_next;

	// One-cycle ack; writes and unmapped reads answer with zero data
	always_comb begin
		ack_next = take;
		dat_next = dat_reg;
		if (take) begin
			dat_next = DAT_ZERO;
			if (!wb_we_i) begin
				dat_next[7:0] = rd_byte;
			end
		end
		flags_next = flag;
	end

	// Registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_reg <= 1'b0;
			dat_reg <= DAT_ZERO;
			flags_reg <= '0;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			flags_reg <= flags_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign stored_flags_o = flags_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Assertion helpers: a taken read of a low or a high byte
	logic low_rd;
	logic high_rd;
	assign low_rd = take && !wb_we_i && hit && !sel_high;
	assign high_rd = take && !wb_we_i && hit && sel_high;

	sequence s_request;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence s_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	a_ack_handshake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_request |=> s_answer)
		else $error("ack not a single cycle after request");

	a_low_fill_ones: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		low_rd |=> wb_dat_o[5:1] == 5'h1F)
		else $error("low byte fill bits not all ones");

	a_low_flag_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		low_rd |=> wb_dat_o[0] == $past(flag[sel_pair]))
		else $error("low byte bit zero does not show the flag");

	a_high_result_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		high_rd |=> wb_dat_o[7:0] == $past(result[sel_pair][9:2]) && wb_dat_o[31:8] == 24'h000000)
		else $error("high byte does not hold upper result bits");

	a_low_result_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		low_rd |=> wb_dat_o[7:6] == $past(result[sel_pair][1:0]))
		else $error("low byte bits seven and six wrong");

	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		take && !hit |=> wb_ack_o && wb_dat_o == 32'h00000000)
		else $error("unmapped access not answered with zero");

	// Ack only ever answers a taken request
	a_ack_only_taken: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!take |=> !wb_ack_o)
		else $error("ack without a taken request");

	// Read data stands between accesses
	a_data_stands: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!take |=> $stable(wb_dat_o))
		else $error("read data changed between accesses");

	// Bus writes leave every stored flag alone
	a_write_no_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		take && wb_we_i && conv_wr == '0 |=> flag == $past(flag))
		else $error("bus write changed a stored flag");

	// Flag output mirrors the internal flags one cycle late
	a_flags_mirror: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rst_n_i |=> stored_flags_o == $past(flag))
		else $error("flag output does not follow the stored flags");

	for (genvar k = 0; k < NUM_PAIRS; k++) begin : g_chk
		a_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			conv_wr[k] |=> flag[k] && result[k] == $past(conv_i.data))
			else $error("converter write did not set the flag");

		a_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			rd_clr[k] && !conv_wr[k] |=> !flag[k] ##1 (flag[k] == $past(conv_wr[k])))
			else $error("read did not clear the flag");

		// A store and a read-clear on one edge leave the flag set
		a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			rd_clr[k] && conv_wr[k] |=> flag[k])
			else $error("read-clear overrode a converter write");

		// Without a store, a result never changes
		a_result_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			!conv_wr[k] |=> result[k] == $past(result[k]))
			else $error("result changed without a converter write");

		// Without a store or a read, the flag keeps its value
		a_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			!rd_clr[k] && !conv_wr[k] |=> flag[k] == $past(flag[k]))
			else $error("flag changed without a store or a read");
	end

endmodule : adcrb_bank

`default_nettype wire

// >>> pkg/adcrb_pkg.sv
// Constants and carrier types for the converter result register bank.
// Assumes one system clock shared by the converter core and the bus.
`default_nettype none

package adcrb_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned NUM_PAIRS = 3;
	localparam int unsigned RES_W = 10;
	localparam int unsigned IDX_W = 8;
	localparam int unsigned ADDR_W = 10;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_PAIR15_LOW = 8'h62;
	localparam logic [7:0] IDX_PAIR15_HIGH = 8'h63;
	localparam logic [7:0] IDX_PAIR26_LOW = 8'h64;
	localparam logic [7:0] IDX_PAIR26_HIGH = 8'h65;
	localparam logic [7:0] IDX_PAIR37_LOW = 8'h66;
	localparam logic [7:0] IDX_PAIR37_HIGH = 8'h67;

	// ----------------------------------------------------------------
	// Low-byte field layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_BIT = 0;
	localparam int unsigned FILL_LSB = 1;
	localparam int unsigned FILL_MSB = 5;
	localparam int unsigned RES_LO_LSB = 6;
	localparam logic [4:0] LOW_FILL = 5'h1F;
	localparam logic [9:0] RESULT_RST = 10'h000;
	localparam logic FLAG_RST = 1'b0;
	localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

	// Converter write carrier: strobe, pair number, ten-bit result
	typedef struct packed {
		logic wr;
		logic [1:0] pair;
		logic [9:0] data;
	} adcrb_conv_s;

endpackage : adcrb_pkg

`default_nettype wire

// >>> hw/adcrb_pair.sv
// One result register pair: ten-bit result and its stored flag.
// Assumes write and read-clear strobes are one-cycle pulses on clk_i.
`default_nettype none

module adcrb_pair
	import adcrb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire logic [9:0] data_i,
	input wire logic rd_clr_i,
	output logic [9:0] result_o,
	output logic flag_o
);

	logic [9:0] result_reg;
	logic [9:0] result_next;
	logic flag_reg;
	logic flag_next;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// A new result sets the flag; a read clears it, set wins
	always_comb begin
		result_next = result_reg;
		flag_next = flag_reg;
		if (rd_clr_i) begin
			flag_next = 1'b0;
		end
		if (wr_i) begin
			result_next = data_i;
			flag_next = 1'b1;
		end
	end

	// Registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			result_reg <= RESULT_RST;
			flag_reg <= FLAG_RST;
		end else begin
			result_reg <= result_next;
			flag_reg <= flag_next;
		end
	end

	assign result_o = result_reg;
	assign flag_o = flag_reg;

endmodule : adcrb_pair

`default_nettype wire

// >>> testbench/adc_result_register_bank_tb.sv
// Self-checking bench for the converter result register bank.
// Assumes one system clock and a single-ack classic Wishbone slave.
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end

module adc_result_register_bank_tb
	import adcrb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ADDR_W-1:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = DAT_ZERO;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	adcrb_conv_s conv_i = '0;
	logic [NUM_PAIRS-1:0] stored_flags_o;
	int mismatches = 0;
	int tests_run = 0;
	logic [7:0] rd;
	logic [9:0] val;
	logic [9:0] inv;

	// ------------------------------------------------------------
	// Clock and design
	// ------------------------------------------------------------
	always #10 clk_i = ~clk_i;

	adcrb_bank dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_i(conv_i), .stored_flags_o(stored_flags_o));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Counts and verdict, then end of run
	task give_verdict;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// One classic cycle, held until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] idx, output logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= 32'hFFFF_FFFF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			give_verdict();
		end
		d = wb_dat_o[7:0];
		`CHK("upper bytes", 24'h000000, wb_dat_o[31:8])
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : bus

	// Converter posts one result as a one-cycle pulse
	task automatic conv_wr(input logic [1:0] p, input logic [9:0] d);
		@(posedge clk_i);
		conv_i <= '{wr: 1'b1, pair: p, data: d};
		@(posedge clk_i);
		conv_i.wr <= 1'b0;
	endtask : conv_wr

	// Low byte image: result bits 1:0, ones filler, flag
	function automatic logic [7:0] exp_low(input logic [9:0] r, input logic f);
		return {r[1:0], 5'h1F, f};
	endfunction : exp_low

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Reset image of every pair
		for (int k = 0; k < 3; k++) begin
			bus(1'b0, 8'(IDX_PAIR15_LOW + 2 * k), rd);
			`CHK("low reset", exp_low(RESULT_RST, FLAG_RST), rd)
			bus(1'b0, 8'(IDX_PAIR15_HIGH + 2 * k), rd);
			`CHK("high reset", 8'h00, rd)
		end
		// Store, read-clear via low, then via high
		for (int k = 0; k < 3; k++) begin
			val = 10'h2A9 ^ 10'(k * 10'h0D3);
			inv = ~val;
			conv_wr(2'(k), val);
			repeat (2) @(posedge clk_i);
			#1 `CHK("flags out", 3'(1 << k), stored_flags_o)
			bus(1'b0, 8'(IDX_PAIR15_LOW + 2 * k), rd);
			`CHK("low set", exp_low(val, 1'b1), rd)
			bus(1'b0, 8'(IDX_PAIR15_LOW + 2 * k), rd);
			`CHK("low cleared", exp_low(val, 1'b0), rd)
			conv_wr(2'(k), inv);
			bus(1'b1, 8'(IDX_PAIR15_LOW + 2 * k), rd);
			`CHK("write data", 8'h00, rd)
			bus(1'b0, 8'(IDX_PAIR15_HIGH + 2 * k), rd);
			`CHK("high byte", inv[9:2], rd)
			bus(1'b0, 8'(IDX_PAIR15_LOW + 2 * k), rd);
			`CHK("high clears", exp_low(inv, 1'b0), rd)
		end
		// Store and read-clear on one edge: the store wins
		fork
			bus(1'b0, IDX_PAIR26_LOW, rd);
			conv_wr(2'd1, 10'h155);
		join
		`CHK("clash flag", 1'b0, rd[0])
		bus(1'b0, IDX_PAIR26_LOW, rd);
		`CHK("clash kept", exp_low(10'h155, 1'b1), rd)
		bus(1'b0, IDX_PAIR26_HIGH, rd);
		`CHK("clash high", 8'h55, rd)
		// Pair three ignored, unmapped index reads zero
		conv_wr(2'd3, 10'h3FF);
		repeat (2) @(posedge clk_i);
		#1 `CHK("flags idle", 3'b000, stored_flags_o)
		bus(1'b0, 8'h68, rd);
		`CHK("unmapped", 8'h00, rd)
		give_verdict();
	end

endmodule : adc_result_register_bank_tb

`default_nettype wire
